/* File: bench/pll_lock_calibration_sequencer_test.sv */
// self-checking bench for the pll lock calibration sequencer
// assumes the behavioural pll register model on the pll side and a 200 MHz core clock
`timescale 1ns/10ps
`include "lock_calib_cfg.svh"
module pll_lock_calibration_sequencer_test;
    import lock_calib_pkg::*;
    localparam int WAIT = 20;   // shortened calibration wait
    logic        core_clk, rst, fifty, cal_reset_low, supply_good;
    logic        sleep0_low, sleep1_low, raw_lock0, raw_lock1;
    apb_req_s    fab_req, pll_req;
    word_t       fab_prdata, pll_prdata, rd, wdata;
    logic        fab_pready, fab_pslverr, pll_pready, pll_pslverr, locked0, locked1, err;
    logic [1:0]  delay;         // pll answer wait, redrawn at random after each completed pll write
    logic [31:0] rng;           // xorshift state
    int          error_cnt, compares, cyc, a, d, c;
    int          s_adr[$], s_dat[$], s_cyc[$];   // completed pll writes

    lock_calib_controller #(.WAIT_CYCLES(WAIT)) u_lock_calib_controller (
        .CORE_CLK(core_clk), .RST(rst), .FIFTY_MHZ_CLOCK(fifty), .CAL_RESET_LOW(cal_reset_low),
        .PLL_SUPPLY_GOOD(supply_good), .UNIT0_SLEEP_LOW(sleep0_low), .UNIT1_SLEEP_LOW(sleep1_low),
        .UNIT0_PLL_LOCK(raw_lock0), .UNIT1_PLL_LOCK(raw_lock1), .FAB_IN(fab_req),
        .FAB_PRDATA(fab_prdata), .FAB_PREADY(fab_pready), .FAB_PSLVERR(fab_pslverr),
        .PLL_OUT(pll_req), .PLL_PRDATA(pll_prdata), .PLL_PREADY(pll_pready),
        .PLL_PSLVERR(pll_pslverr), .UNIT0_LOCKED(locked0), .UNIT1_LOCKED(locked1));
    pll_reg_model u_pll_reg_model (.clk(core_clk), .rst(rst), .req(pll_req), .delay(delay),
        .prdata(pll_prdata), .pready(pll_pready), .pslverr(pll_pslverr));

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    // core clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // 50 MHz reference as a sampled input, four core cycles a period
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc % 2 == 1) fifty <= ~fifty;
    end

    // log completed pll writes; new random wait for the next transfer
    always @(posedge core_clk) begin
        if (pll_req.psel && pll_req.penable && pll_pready === 1'b1 && pll_req.pwrite) begin
            s_adr.push_back(int'(pll_req.paddr));
            s_dat.push_back(int'(pll_req.pwdata));
            s_cyc.push_back(cyc);
            rng <= xs(rng);
            delay <= rng[1:0];
        end
    end

    task automatic wrap_up;
        if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic give_up(input string what);
        chk(what, 32'h1, 32'h0);
        wrap_up();
    endtask : give_up

    // next completed pll write, bounded wait
    task automatic pop;
        for (int n = 0; n < 20000; n++) begin
            @(posedge core_clk);
            if (s_adr.size() > 0) begin
                a = s_adr.pop_front();
                d = s_dat.pop_front();
                c = s_cyc.pop_front();
                return;
            end
        end
        give_up("pll write timeout");
    endtask : pop

    // fabric apb transfer: setup, access held until pready sampled high
    task automatic apb(input logic wr, input addr_t ad, input word_t wd);
        // idle edge first: the previous release and this setup never share a time step
        @(posedge core_clk);
        fab_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: ad, pwdata: wd};
        @(posedge core_clk);
        fab_req.penable <= 1'b1;
        for (int n = 0; n < 40000; n++) begin
            @(posedge core_clk);
            if (fab_pready === 1'b1) begin
                rd = fab_prdata;
                err = fab_pslverr;
                fab_req <= '0;
                return;
            end
        end
        give_up("fabric apb timeout");
    endtask : apb

    // model of one calibration pass over the units in mask
    task automatic cal(input logic [1:0] mask);
        int rv, hv, c_hi;
        bit first;
        first = 1'b1;
        for (int u = 0; u < 2; u++) begin
            if (mask[u]) begin
                rv = (u == 0) ? `UNIT0_FBDIV_RST : `UNIT1_FBDIV_RST;
                hv = rv * 7 / 4;
                pop();
                c_hi = c;
                chk("raised addr", 32'h010 + (u << 10), a);
                chk("raised data", hv, d & 32'hFFFF);
                chk("raised ratio", 1, ((d & 32'hFFFF) * 10 >= rv * 15) && ((d & 32'hFFFF) * 10 <= rv * 19));
                if (first) begin
                    @(posedge core_clk);
                    chk("locked0 busy", !mask[0], locked0);
                    chk("locked1 busy", !mask[1], locked1);
                end
                first = 1'b0;
                pop();
                chk("real addr", 32'h010 + (u << 10), a);
                chk("real data", rv, d & 32'hFFFF);
                chk("wait gap", 1, (c - c_hi) >= WAIT + 4);
            end
        end
        repeat (3) @(posedge core_clk);
        chk("locked0 done", 1, locked0);
        chk("locked1 done", 1, locked1);
        chk("extra writes", 0, s_adr.size());
    endtask : cal

    initial begin
        rst = 1'b1;
        fifty = 1'b0;
        cal_reset_low = 1'b1;
        supply_good = 1'b1;
        sleep0_low = 1'b1;
        sleep1_low = 1'b1;
        raw_lock0 = 1'b1;
        raw_lock1 = 1'b1;
        fab_req = '0;
        delay = 2'h1;
        rng = 32'hAB79;
        cyc = 0;
        error_cnt = 0;
        compares = 0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        cal(2'h3);
        apb(1'b0, `REG_CTRL, 32'h0);
        chk("ctrl reset", 32'h1, rd);
        apb(1'b1, `REG_STATUS, 32'hFF);
        chk("status write refused", 1, err);
        apb(1'b0, 12'h008, 32'h0);
        chk("unmapped refused", 1, err);
        apb(1'b0, 12'hC10, 32'h0);
        chk("window off refused", 1, err);
        // lock loss on unit zero only
        raw_lock0 <= 1'b0;
        repeat (3) @(posedge core_clk);
        raw_lock0 <= 1'b1;
        cal(2'h1);
        // unit one asleep: its lock stays low, unit zero untouched
        sleep1_low <= 1'b0;
        repeat (10) @(posedge core_clk);
        chk("sleep locked1", 0, locked1);
        chk("sleep locked0", 1, locked0);
        sleep1_low <= 1'b1;
        cal(2'h2);
        supply_good <= 1'b0;
        repeat (3) @(posedge core_clk);
        supply_good <= 1'b1;
        cal(2'h3);
        // default style waits for the 50 MHz edges before acting
        cal_reset_low <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("sync assert late", 1, locked0);
        repeat (20) @(posedge core_clk);
        chk("sync assert", 0, locked0);
        cal_reset_low <= 1'b1;
        cal(2'h3);
        // alternate style acts at once
        apb(1'b1, `REG_CTRL, 32'h5);
        // bench reset is registered on the core clock, free of transients
        cal_reset_low <= 1'b0;
        // pending one edge later, lock output one more: far sooner than two 50 MHz edges
        repeat (3) @(posedge core_clk);
        chk("async assert", 0, locked0);
        repeat (10) @(posedge core_clk);
        cal_reset_low <= 1'b1;
        cal(2'h3);
        // dynamic window to unit one
        apb(1'b1, `REG_CTRL, 32'h3);
        wdata = xs(rng ^ 32'h5A5A);
        // reconfigure only with both locks up, and away from the oscillator register
        chk("window locks", 1, locked0 & locked1);
        apb(1'b1, 12'hC20, wdata);
        chk("window write ok", 0, err);
        pop();
        chk("window pll addr", 32'h420, a);
        chk("window pll data", wdata, d);
        apb(1'b0, 12'hC20, 32'h0);
        chk("window read", wdata, rd);
        wrap_up();
    end
endmodule : pll_lock_calibration_sequencer_test

/* File: bench/pll_reg_model.sv */
// behavioural pll register port: apb target with a wait set per transfer
// assumes apb order from the sequencer; delay is set by the bench between transfers
`timescale 1ns/10ps
module pll_reg_model (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire lock_calib_pkg::apb_req_s req,
    input  wire logic [1:0]               delay,
    output      lock_calib_pkg::word_t    prdata,
    output      logic                     pready,
    output      logic                     pslverr
);
    import lock_calib_pkg::*;
    word_t      mem [0:4095];   // register image, one word per byte address
    logic [1:0] cnt;            // access cycles spent so far
    word_t      junk;           // floating bus pattern, changes every cycle

    // access wait counter and register update at the completing edge
    always_ff @(posedge clk) begin
        if (rst || !(req.psel && req.penable) || pready) begin
            cnt <= 2'h0;
        end else begin
            cnt <= cnt + 2'h1;
        end
        if (pready && req.pwrite) begin
            mem[req.paddr] <= req.pwdata;
        end
        junk <= rst ? 32'h1234_5A5A : {junk[30:0], ~junk[31]};
    end

    // slow answers keep the sequencer honest about holding its request
    assign pready  = req.psel && req.penable && (cnt == delay);
    assign pslverr = 1'b0;

    // read data only valid with pready; otherwise a moving pattern, not a stale word
    always_comb begin
        prdata = (pready && !req.pwrite) ? mem[req.paddr] : junk;
    end
endmodule : pll_reg_model

/* File: pkg/lock_calib_cfg.svh */
// constants of the pll lock calibration sequencer: offsets, fields, resets, timing
// assumes a 200 MHz core clock and 32-bit APB on both the fabric and the pll side
// Contract
// - calibrate after power-up and unit reset
// - write pll registers as APB initiator
// - write raised setting, wait 150 us, write real
// - raised setting is 1.5 to 1.9 times real
// - unit zero loads before unit one
// - lock loss restarts calibration when enabled
// - calibration reset reruns sequence after release
// - sleep low recalibrates that unit only
// - supply not ready recalibrates every unit
// - lock output low while unit recalibrates
// - default reset style fully synchronous to 50 MHz
// - alternate style: immediate assert, synchronous release
// - reset synchroniser built in for both styles
// - one shared APB target for dynamic reconfiguration
// - recalibration overwrites fabric-written pll values (only the oscillator feedback divider register is rewritten)
`ifndef LOCK_CALIB_CFG_SVH
`define LOCK_CALIB_CFG_SVH

// timing
`define CORE_CLK_MHZ     200
`define CAL_WAIT_US      150
`define CAL_WAIT_CYCLES  (`CAL_WAIT_US * `CORE_CLK_MHZ)

// fabric-side register map, byte addresses
`define REG_CTRL         12'h000
`define REG_STATUS       12'h004
`define WIN_BIT          11
`define WIN_UNIT_BIT     10

// control fields and reset value
`define CTRL_AUTO        0
`define CTRL_DYN         1
`define CTRL_ASYNC       2
`define CTRL_RST         3'h1

// pll side: offset of the oscillator feedback divider register
`define VCO_REG_OFS      10'h010

// raised setting = real * HI_NUM >> HI_SHIFT (1.75x)
`define HI_NUM           18'h00007
`define HI_SHIFT         2
`define RATIO_LO_X10     32'd15
`define RATIO_HI_X10     32'd19
`define RATIO_ONE_X10    32'd10

// default configuration
`define UNITS_USED_RST   2'h3
`define UNIT0_FBDIV_RST  16'h0020
`define UNIT1_FBDIV_RST  16'h0028

`endif

/* File: pkg/lock_calib_pkg.sv */
// types shared by the calibration sequencer files
// assumes the constants header is included by whoever needs numbers
package lock_calib_pkg;
    typedef logic [31:0] word_t;             // apb data word
    typedef logic [11:0] addr_t;             // apb byte address
    typedef logic [15:0] fbdiv_t;            // feedback divider value

    typedef enum logic [1:0] {S_IDLE, S_HIGH, S_WAIT, S_ACTUAL} seq_state_e;
    typedef enum logic [1:0] {M_IDLE, M_SETUP, M_ACCESS} mst_state_e;

    // apb request as seen on a bus, used for both directions
    typedef struct packed {
        logic  psel;
        logic  penable;
        logic  pwrite;
        addr_t paddr;
        word_t pwdata;
    } apb_req_s;
endpackage : lock_calib_pkg

/* File: rtl/cal_reset_sync.sv */
// reset conditioner for the active-low calibration reset
// assumes the 50 MHz clock and reset pin are synchronous to the core clock
`timescale 1ns/10ps
`include "lock_calib_cfg.svh"
module cal_reset_sync (
    input  logic clk,
    input  logic rst,
    input  logic fifty_clk,
    input  logic reset_low,
    input  logic async_style,
    output logic cal_rst
);
    logic       fifty_prev;   // last sample of the 50 MHz clock
    logic       tick;         // rising edge of the 50 MHz clock
    logic [1:0] stage;        // two-stage release pipe

    assign tick = fifty_clk & ~fifty_prev;

    // edge detect of the slow clock
    always_ff @(posedge clk) begin
        if (rst) begin
            fifty_prev <= 1'b0;
        end else begin
            fifty_prev <= fifty_clk;
        end
    end

    // asserted state held through core reset so calibration follows it
    always_ff @(posedge clk) begin
        if (rst) begin
            stage <= 2'h3;
        end else if (async_style && !reset_low) begin
            stage <= 2'h3;
        end else if (tick) begin
            stage <= {stage[0], ~reset_low};
        end
    end

    // async style bypasses the pipe on assertion only
    assign cal_rst = stage[1] | (async_style & ~reset_low);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_sync_on_tick: assert property (
        (!async_style && $changed(stage[1])) |-> $past(tick))
        else $error("sync reset changed off a 50 MHz edge");
    chk_async_assert: assert property (
        (async_style && !reset_low) |=> (stage == 2'h3) ##0 cal_rst)
        else $error("async reset assertion not immediate");
endmodule : cal_reset_sync

/* File: rtl/lock_calib_controller.sv */
// calibration sequencer for two clock-conditioning plls with fabric APB target
// assumes one core clock, pll register port on APB, inputs synchronous to CORE_CLK
`timescale 1ns/10ps
`include "lock_calib_cfg.svh"
module lock_calib_controller #(
    parameter int                       WAIT_CYCLES = `CAL_WAIT_CYCLES,
    parameter logic [1:0]               UNITS_USED  = `UNITS_USED_RST,
    parameter lock_calib_pkg::fbdiv_t   UNIT0_FBDIV = `UNIT0_FBDIV_RST,
    parameter lock_calib_pkg::fbdiv_t   UNIT1_FBDIV = `UNIT1_FBDIV_RST
) (
    input  logic                     CORE_CLK,
    input  logic                     RST,
    input  logic                     FIFTY_MHZ_CLOCK,
    input  logic                     CAL_RESET_LOW,
    input  logic                     PLL_SUPPLY_GOOD,
    input  logic                     UNIT0_SLEEP_LOW,
    input  logic                     UNIT1_SLEEP_LOW,
    input  logic                     UNIT0_PLL_LOCK,
    input  logic                     UNIT1_PLL_LOCK,
    input  lock_calib_pkg::apb_req_s FAB_IN,
    output lock_calib_pkg::word_t    FAB_PRDATA,
    output logic                     FAB_PREADY,
    output logic                     FAB_PSLVERR,
    output lock_calib_pkg::apb_req_s PLL_OUT,
    input  lock_calib_pkg::word_t    PLL_PRDATA,
    input  logic                     PLL_PREADY,
    input  logic                     PLL_PSLVERR,
    output logic                     UNIT0_LOCKED,
    output logic                     UNIT1_LOCKED
);
    import lock_calib_pkg::*;

    // one-hot mask of a unit
    function automatic logic [1:0] unit_mask(input logic u);
        unit_mask = u ? 2'h2 : 2'h1;
    endfunction : unit_mask

    // pll-side address: unit select above the register offset
    function automatic addr_t pll_addr(input logic u, input logic [9:0] ofs);
        pll_addr = {1'b0, u, ofs};
    endfunction : pll_addr

    // raised oscillator setting, 1.75 times the real one
    function automatic fbdiv_t hi_vco(input fbdiv_t f);
        logic [17:0] prod;
        prod = {2'h0, f} * `HI_NUM;
        hi_vco = prod[17:`HI_SHIFT];
    endfunction : hi_vco

    logic       cal_rst;        // conditioned calibration reset, active high
    logic [2:0] ctrl;           // auto-reset, dynamic config, async style
    logic [1:0] raw_lock;       // lock straight from the plls
    logic [1:0] lock_prev;      // lock one cycle ago
    logic [1:0] sleep_ok;       // unit awake (forced when single unit)
    logic [1:0] pend;           // unit waits for calibration
    logic [1:0] set_pend;       // new calibration events
    logic [1:0] clr_pend;       // unit taken by the sequencer
    logic [1:0] owned;          // unit pending or being calibrated
    logic [1:0] can;            // pending and allowed to start
    logic       supply_prev;    // supply-good one cycle ago
    logic       start;          // sequencer starts a unit
    logic       start_unit;     // unit it starts
    seq_state_e seq;            // sequencer state
    logic       cur_unit;       // unit under calibration
    logic [31:0] wait_cnt;      // settle wait down-counter
    logic [31:0] wait_seen;     // cycles spent waiting, checked only
    logic       seq_req;        // sequencer wants a pll write
    fbdiv_t     real_div;       // real divider of current unit
    word_t      seq_data;       // word the sequencer writes
    mst_state_e mst;            // pll-side initiator state
    logic       owner_seq;      // current transfer belongs to sequencer
    logic       mst_done;       // transfer finished, one cycle
    word_t      mst_rdata;      // read data of last transfer
    logic       mst_err;        // error flag of last transfer
    logic       fab_req;        // forwarded fabric access outstanding
    logic       fab_unit;       // unit the fabric access targets
    logic       fab_go;         // forwarded access may launch
    logic       fab_new;        // fresh fabric access phase
    logic       ctrl_wr;        // software writes control

    cal_reset_sync u_rsync (
        .clk         (CORE_CLK),
        .rst         (RST),
        .fifty_clk   (FIFTY_MHZ_CLOCK),
        .reset_low   (CAL_RESET_LOW),
        .async_style (ctrl[`CTRL_ASYNC]),
        .cal_rst     (cal_rst)
    );

    assign raw_lock = {UNIT1_PLL_LOCK, UNIT0_PLL_LOCK};
    // power-down only matters with both units in use
    assign sleep_ok = (UNITS_USED == 2'h3) ? {UNIT1_SLEEP_LOW, UNIT0_SLEEP_LOW} : 2'h3;
    assign owned    = pend | ((seq != S_IDLE) ? unit_mask(cur_unit) : 2'h0);

    // edge history for lock and supply
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            lock_prev   <= 2'h0;
            supply_prev <= 1'b1;
        end else begin
            lock_prev   <= raw_lock;
            supply_prev <= PLL_SUPPLY_GOOD;
        end
    end

    // calibration events
    always_comb begin
        set_pend = 2'h0;
        if (cal_rst) begin
            set_pend = 2'h3;
        end
        if (supply_prev && !PLL_SUPPLY_GOOD) begin
            set_pend = 2'h3;
        end
        if (ctrl[`CTRL_AUTO]) begin
            set_pend = set_pend | (lock_prev & ~raw_lock & ~owned);
        end
        if (UNITS_USED == 2'h3) begin
            set_pend = set_pend | ~sleep_ok;
        end
        set_pend = set_pend & UNITS_USED;
    end

    // pending flags; a new event beats the clear in the same cycle
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            pend <= UNITS_USED;
        end else begin
            pend <= (pend & ~clr_pend) | set_pend;
        end
    end

    // start only with supply good, unit awake and reset released
    assign can        = pend & sleep_ok & {2{PLL_SUPPLY_GOOD & ~cal_rst}};
    assign start      = (seq == S_IDLE) && (can != 2'h0);
    assign start_unit = ~can[0];
    assign clr_pend   = start ? unit_mask(start_unit) : 2'h0;

    // sequencer: raised write, settle wait, real write
    always_ff @(posedge CORE_CLK) begin
        if (RST || cal_rst) begin
            seq      <= S_IDLE;
            cur_unit <= 1'b0;
            wait_cnt <= 32'h0;
        end else begin
            case (seq)
                S_IDLE: begin
                    if (start) begin
                        seq      <= S_HIGH;
                        cur_unit <= start_unit;
                    end
                end
                S_HIGH: begin
                    if (mst_done && owner_seq) begin
                        seq      <= S_WAIT;
                        wait_cnt <= 32'(WAIT_CYCLES - 1);
                    end
                end
                S_WAIT: begin
                    if (wait_cnt == 32'h0) begin
                        seq <= S_ACTUAL;
                    end else begin
                        wait_cnt <= wait_cnt - 32'h1;
                    end
                end
                S_ACTUAL: begin
                    if (mst_done && owner_seq) begin
                        seq <= S_IDLE;
                    end
                end
                default: begin
                    seq <= S_IDLE;
                end
            endcase
        end
    end

    // wait length seen, read by checks only
    always_ff @(posedge CORE_CLK) begin
        if (RST || seq != S_WAIT) begin
            wait_seen <= 32'h0;
        end else begin
            wait_seen <= wait_seen + 32'h1;
        end
    end

    // data of the two calibration writes; real write wipes fabric edits to the feedback divider register only
    assign real_div = cur_unit ? UNIT1_FBDIV : UNIT0_FBDIV;
    assign seq_data = {16'h0, (seq == S_HIGH) ? hi_vco(real_div) : real_div};
    // guard on done stops a second launch before the state moves
    assign seq_req  = ((seq == S_HIGH) || (seq == S_ACTUAL)) && !mst_done;
    // fabric waits while the sequence owns its unit
    assign fab_go   = fab_req && !mst_done && !owned[fab_unit] && !seq_req;

    // pll-side APB initiator; sequencer has priority over fabric
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            mst       <= M_IDLE;
            PLL_OUT   <= '0;
            owner_seq <= 1'b0;
            mst_done  <= 1'b0;
            mst_rdata <= 32'h0;
            mst_err   <= 1'b0;
        end else begin
            mst_done <= 1'b0;
            case (mst)
                M_IDLE: begin
                    if (seq_req) begin
                        PLL_OUT   <= '{1'b1, 1'b0, 1'b1, pll_addr(cur_unit, `VCO_REG_OFS), seq_data};
                        owner_seq <= 1'b1;
                        mst       <= M_SETUP;
                    end else if (fab_go) begin
                        PLL_OUT   <= '{1'b1, 1'b0, FAB_IN.pwrite, pll_addr(fab_unit, FAB_IN.paddr[9:0]),
                                       FAB_IN.pwdata};
                        owner_seq <= 1'b0;
                        mst       <= M_SETUP;
                    end
                end
                M_SETUP: begin
                    PLL_OUT.penable <= 1'b1;
                    mst             <= M_ACCESS;
                end
                M_ACCESS: begin
                    if (PLL_PREADY) begin
                        PLL_OUT.psel    <= 1'b0;
                        PLL_OUT.penable <= 1'b0;
                        mst_rdata       <= PLL_PRDATA;
                        mst_err         <= PLL_PSLVERR;
                        mst_done        <= 1'b1;
                        mst             <= M_IDLE;
                    end
                end
                default: begin
                    mst <= M_IDLE;
                end
            endcase
        end
    end

    // fabric APB target: local registers or window onto the plls
    assign fab_new = FAB_IN.psel && FAB_IN.penable && !FAB_PREADY && !fab_req;
    assign ctrl_wr = fab_new && !FAB_IN.paddr[`WIN_BIT] && FAB_IN.pwrite && (FAB_IN.paddr == `REG_CTRL);

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            FAB_PREADY  <= 1'b0;
            FAB_PSLVERR <= 1'b0;
            FAB_PRDATA  <= 32'h0;
            fab_req     <= 1'b0;
            fab_unit    <= 1'b0;
        end else begin
            FAB_PREADY  <= 1'b0;
            FAB_PSLVERR <= 1'b0;
            if (fab_req) begin
                // forwarded access completes with the pll answer
                if (mst_done && !owner_seq) begin
                    fab_req     <= 1'b0;
                    FAB_PREADY  <= 1'b1;
                    FAB_PSLVERR <= mst_err;
                    FAB_PRDATA  <= FAB_IN.pwrite ? 32'h0 : mst_rdata;
                end
            end else if (fab_new) begin
                FAB_PREADY <= 1'b1;
                FAB_PRDATA <= 32'h0;
                if (FAB_IN.paddr[`WIN_BIT]) begin
                    if (ctrl[`CTRL_DYN]) begin
                        FAB_PREADY <= 1'b0;
                        fab_req    <= 1'b1;
                        fab_unit   <= FAB_IN.paddr[`WIN_UNIT_BIT];
                    end else begin
                        FAB_PSLVERR <= 1'b1; // window closed
                    end
                end else if (FAB_IN.paddr == `REG_CTRL) begin
                    FAB_PRDATA <= {29'h0, ctrl};
                end else if (FAB_IN.paddr == `REG_STATUS) begin
                    if (FAB_IN.pwrite) begin
                        FAB_PSLVERR <= 1'b1; // status is read only
                    end
                    FAB_PRDATA <= {23'h0, cur_unit, cal_rst, seq != S_IDLE,
                                   UNIT1_LOCKED, UNIT0_LOCKED, raw_lock, pend};
                end else begin
                    FAB_PSLVERR <= 1'b1; // unmapped
                end
            end
        end
    end

    // control register
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ctrl <= `CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl <= FAB_IN.pwdata[2:0];
        end
    end

    // lock outputs forced low while the unit is owned
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            UNIT0_LOCKED <= 1'b0;
            UNIT1_LOCKED <= 1'b0;
        end else begin
            UNIT0_LOCKED <= raw_lock[0] & ~owned[0] & UNITS_USED[0];
            UNIT1_LOCKED <= raw_lock[1] & ~owned[1] & UNITS_USED[1];
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    chk_lock_held_low: assert property (
        (owned[0] |=> !UNIT0_LOCKED) and (owned[1] |=> !UNIT1_LOCKED))
        else $error("lock output high while unit recalibrates");
    chk_wait_length: assert property (
        (seq == S_WAIT && wait_cnt == 32'h0 && !cal_rst)
            |-> (wait_seen == 32'(WAIT_CYCLES - 1)) ##1 (seq == S_ACTUAL))
        else $error("settle wait has wrong length");
    chk_raised_ratio: assert property (
        (PLL_OUT.psel && owner_seq && seq == S_HIGH)
            |-> (32'(PLL_OUT.pwdata[15:0]) * `RATIO_ONE_X10 >= 32'(real_div) * `RATIO_LO_X10)
             && (32'(PLL_OUT.pwdata[15:0]) * `RATIO_ONE_X10 <= 32'(real_div) * `RATIO_HI_X10))
        else $error("raised setting out of ratio range");
    chk_unit_order: assert property (
        (start && start_unit) |-> !can[0])
        else $error("unit one started before unit zero");
    chk_lock_loss: assert property (
        (ctrl[`CTRL_AUTO] && UNITS_USED[0] && lock_prev[0] && !raw_lock[0]) |=> owned[0])
        else $error("lock loss did not start calibration");
    chk_sleep_recal: assert property (
        (UNITS_USED == 2'h3 && !UNIT1_SLEEP_LOW) |=> pend[1] && (seq == S_IDLE || !cur_unit))
        else $error("sleep did not recalibrate its unit");
    chk_supply_drop: assert property (
        (supply_prev && !PLL_SUPPLY_GOOD) |=> ((owned & UNITS_USED) == UNITS_USED))
        else $error("supply drop did not recalibrate all units");
    chk_reset_rerun: assert property (
        cal_rst |=> (seq == S_IDLE) && ((pend & UNITS_USED) == UNITS_USED))
        else $error("calibration reset did not rearm sequence");
    chk_apb_hold: assert property (
        (PLL_OUT.psel && !PLL_OUT.penable) |=> PLL_OUT.psel && PLL_OUT.penable
            && $stable(PLL_OUT.paddr) && $stable(PLL_OUT.pwdata) && $stable(PLL_OUT.pwrite))
        else $error("pll request not held into access phase");
    chk_fabric_holdoff: assert property (
        (mst == M_IDLE && fab_go) |-> !owned[fab_unit] ##1 !owner_seq)
        else $error("fabric access launched on owned unit");
endmodule : lock_calib_controller
